// ### hw/slot_seq_consts.vh
`ifndef SLOT_SEQ_CONSTS_VH
`define SLOT_SEQ_CONSTS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_MODE 8'h04
`define REG_STATUS 8'h08
`define REG_TONE 8'h0c
`define REG_DLY_POWER 8'h10
`define REG_DLY_WAKE 8'h14
`define REG_DLY_ENABLE 8'h18
`define REG_DLY_DISABLE 8'h1c
`define REG_DLY_TEARDOWN 8'h20
`define REG_MSG 8'h24

// Control register bits (write-one pulses)
`define CTRL_START 0
`define CTRL_DEFAULTS 1

// Mode register bits
`define MODE_KEYED 0
`define MODE_ALIAS 1
`define MODE_FM 2
`define MODE_CHIRP_GATE 3

// Message command register fields
`define MSG_KIND_LO 0
`define MSG_KIND_HI 1
`define MSG_LAST 2
`define MSG_LEN_LO 8
`define MSG_LEN_HI 23

// Message element kinds
`define KIND_TONE 2'h0
`define KIND_GAP 2'h1
`define KIND_CHIRP 2'h2
`define KIND_SPEECH 2'h3

// Default slot delays in timebase ticks (1 ms ticks), then the default tone value
`define DLY_POWER_RST 16'h000a
`define DLY_WAKE_RST 16'h05dc
`define DLY_ENABLE_RST 16'h0064
`define DLY_DISABLE_RST 16'h000a
`define DLY_TEARDOWN_RST 16'h000a
`define TONE_RST 16'h0320

// Timebase: tick period in ns and clock period in ns
`define TICK_NS 1000000
`define CLK_NS 5
`define TICK_CYCLES (`TICK_NS / `CLK_NS)

`endif

// ### hw/tick_divider.v
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter integer DIV = 200000
) (
  input wire i_sys_clk,
  input wire i_rst,
  output reg o_tick
);
  localparam integer W = $clog2(DIV);
  reg [W-1:0] cnt_r;

  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= {W{1'b0}};
      o_tick <= 1'b0;
    end
    else if (cnt_r == DIV[W-1:0] - 1'b1)
    begin
      cnt_r <= {W{1'b0}};
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule // tick_divider
`default_nettype wire

// ### hw/axil_regs.v
`timescale 1ns/1ps
`default_nettype none
// Minimal AXI4-Lite slave front end; one write and one read in flight
module axil_regs (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output reg o_wr_en,
  output reg [7:0] o_wr_addr,
  output reg [31:0] o_wr_data,
  output reg [3:0] o_wr_strb,
  input wire i_wr_ok,
  output wire o_rd_en,
  output wire [7:0] o_rd_addr,
  input wire [31:0] i_rd_data,
  input wire i_rd_ok
);
  reg aw_have_r;
  reg w_have_r;
  reg [7:0] aw_r;
  reg [31:0] w_r;
  reg [3:0] s_r;
  reg wr_pend_r;

  assign o_rd_en = i_arvalid && o_arready;
  assign o_rd_addr = i_araddr;

  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_r <= 8'h00;
      w_r <= 32'h0;
      s_r <= 4'h0;
      o_wr_en <= 1'b0;
      o_wr_addr <= 8'h00;
      o_wr_data <= 32'h0;
      o_wr_strb <= 4'h0;
      wr_pend_r <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'b00;
    end
    else
    begin
      o_wr_en <= 1'b0;
      if (i_awvalid && o_awready)
      begin
        aw_r <= i_awaddr;
        aw_have_r <= 1'b1;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_r <= i_wdata;
        s_r <= i_wstrb;
        w_have_r <= 1'b1;
        o_wready <= 1'b0;
      end
      if (aw_have_r && w_have_r && !wr_pend_r && !o_bvalid)
      begin
        o_wr_en <= 1'b1;
        o_wr_addr <= aw_r;
        o_wr_data <= w_r;
        o_wr_strb <= s_r;
        wr_pend_r <= 1'b1;
      end
      if (wr_pend_r)
      begin
        wr_pend_r <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_ok ? 2'b00 : 2'b10;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= i_rd_data;
        o_rresp <= i_rd_ok ? 2'b00 : 2'b10;
      end
      if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule // axil_regs
`default_nettype wire

// ### hw/rf_transmit_slot_sequencer.v
// Contract
// - Each timed slot has programmable, resettable delay
// - Power slot raises board power, waits
// - Wake slot follows, raises power-down control
// - Enable slot raises carrier, waits to stabilize
// - Message slot untimed; lasts message length
// - Disable slot drops carrier, quiet wait
// - Teardown drops control and board power
// - Chirp gating drops board power between chirps
// - Keyed mode: carrier follows tone gate
// - Two mode names one flag; FM clears
// - Keyed speech: carrier on per fragment
// - Zero tone frequency disables tone
`timescale 1ns/1ps
`default_nettype none
`include "slot_seq_consts.vh"
module rf_transmit_slot_sequencer #(
  parameter integer TICK_CYCLES = `TICK_CYCLES
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output wire [1:0] o_bresp,
  output wire o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  output wire o_rvalid,
  input wire i_rready,
  output reg o_rf_board_power,
  output reg o_rf_power_down_ctl,
  output reg o_carrier_enable,
  output reg o_tone_gate
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_POWER = 3'd1;
  localparam [2:0] ST_WAKE = 3'd2;
  localparam [2:0] ST_ENABLE = 3'd3;
  localparam [2:0] ST_MESSAGE = 3'd4;
  localparam [2:0] ST_DISABLE = 3'd5;
  localparam [2:0] ST_TEARDOWN = 3'd6;

  wire tick;
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [7:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_ok;
  reg wr_ok;

  reg [15:0] dly_power_r;
  reg [15:0] dly_wake_r;
  reg [15:0] dly_enable_r;
  reg [15:0] dly_disable_r;
  reg [15:0] dly_teardown_r;
  reg [15:0] tone_r;
  reg keyed_r;
  reg chirp_gate_r;
  reg [2:0] state_r;
  reg [15:0] cnt_r;
  reg elem_valid_r;
  reg [1:0] elem_kind_r;
  reg elem_last_r;
  reg [15:0] elem_len_r;
  reg elem_busy_r;
  reg msg_done_r;
  reg start_pend_r;
  reg [15:0] cur_dly;
  wire wr_full = (wr_strb == 4'hf);

  tick_divider #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  axil_regs u_bus (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_ok(wr_ok),
    .o_rd_en(),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_ok(rd_ok)
  );

  // Read mux; byte lanes ignored on reads
  always @*
  begin
    rd_ok = 1'b1;
    case (rd_addr)
      `REG_CTRL: rd_data = 32'h0;
      `REG_MODE: rd_data = {28'h0, chirp_gate_r, ~keyed_r, keyed_r, keyed_r};
      `REG_STATUS: rd_data = {20'h0, elem_busy_r, elem_valid_r, msg_done_r, start_pend_r, 1'b0, state_r,
                              o_tone_gate, o_carrier_enable, o_rf_power_down_ctl, o_rf_board_power};
      `REG_TONE: rd_data = {16'h0, tone_r};
      `REG_DLY_POWER: rd_data = {16'h0, dly_power_r};
      `REG_DLY_WAKE: rd_data = {16'h0, dly_wake_r};
      `REG_DLY_ENABLE: rd_data = {16'h0, dly_enable_r};
      `REG_DLY_DISABLE: rd_data = {16'h0, dly_disable_r};
      `REG_DLY_TEARDOWN: rd_data = {16'h0, dly_teardown_r};
      `REG_MSG: rd_data = 32'h0;
      default:
      begin
        rd_data = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Whole-word writes only; partial strobes are dropped but answered
  always @*
  begin
    case (wr_addr)
      `REG_CTRL, `REG_MODE, `REG_STATUS, `REG_TONE, `REG_DLY_POWER, `REG_DLY_WAKE,
      `REG_DLY_ENABLE, `REG_DLY_DISABLE, `REG_DLY_TEARDOWN, `REG_MSG: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @*
  begin
    case (state_r)
      ST_POWER: cur_dly = dly_power_r;
      ST_WAKE: cur_dly = dly_wake_r;
      ST_ENABLE: cur_dly = dly_enable_r;
      ST_DISABLE: cur_dly = dly_disable_r;
      ST_TEARDOWN: cur_dly = dly_teardown_r;
      default: cur_dly = 16'h0000;
    endcase
  end

  // Configuration registers
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dly_power_r <= `DLY_POWER_RST;
      dly_wake_r <= `DLY_WAKE_RST;
      dly_enable_r <= `DLY_ENABLE_RST;
      dly_disable_r <= `DLY_DISABLE_RST;
      dly_teardown_r <= `DLY_TEARDOWN_RST;
      tone_r <= `TONE_RST;
      keyed_r <= 1'b0;
      chirp_gate_r <= 1'b0;
    end
    else if (wr_en && wr_full)
    begin
      case (wr_addr)
        `REG_CTRL:
          if (wr_data[`CTRL_DEFAULTS])
          begin
            dly_power_r <= `DLY_POWER_RST;
            dly_wake_r <= `DLY_WAKE_RST;
            dly_enable_r <= `DLY_ENABLE_RST;
            dly_disable_r <= `DLY_DISABLE_RST;
            dly_teardown_r <= `DLY_TEARDOWN_RST;
          end
        `REG_MODE:
        begin
          // Either name sets the flag; FM selection wins as the clear
          keyed_r <= (wr_data[`MODE_KEYED] | wr_data[`MODE_ALIAS]) & ~wr_data[`MODE_FM];
          chirp_gate_r <= wr_data[`MODE_CHIRP_GATE];
        end
        `REG_TONE: tone_r <= wr_data[15:0];
        `REG_DLY_POWER: dly_power_r <= wr_data[15:0];
        `REG_DLY_WAKE: dly_wake_r <= wr_data[15:0];
        `REG_DLY_ENABLE: dly_enable_r <= wr_data[15:0];
        `REG_DLY_DISABLE: dly_disable_r <= wr_data[15:0];
        `REG_DLY_TEARDOWN: dly_teardown_r <= wr_data[15:0];
        default: ;
      endcase
    end
  end

  // Slot sequencer and message element player
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      start_pend_r <= 1'b0;
      elem_valid_r <= 1'b0;
      elem_kind_r <= `KIND_GAP;
      elem_last_r <= 1'b0;
      elem_len_r <= 16'h0000;
      elem_busy_r <= 1'b0;
      msg_done_r <= 1'b0;
      o_rf_board_power <= 1'b0;
      o_rf_power_down_ctl <= 1'b0;
      o_carrier_enable <= 1'b0;
      o_tone_gate <= 1'b0;
    end
    else
    begin
      // One element slot; software polls status before loading the next
      if (wr_en && wr_full && wr_addr == `REG_MSG && !elem_valid_r)
      begin
        elem_valid_r <= 1'b1;
        elem_kind_r <= wr_data[`MSG_KIND_HI:`MSG_KIND_LO];
        elem_last_r <= wr_data[`MSG_LAST];
        elem_len_r <= wr_data[`MSG_LEN_HI:`MSG_LEN_LO];
      end
      case (state_r)
        ST_IDLE:
          if (start_pend_r)
          begin
            start_pend_r <= 1'b0;
            msg_done_r <= 1'b0;
            state_r <= ST_POWER;
            cnt_r <= 16'h0000;
            o_rf_board_power <= 1'b1;
          end
        ST_POWER, ST_WAKE, ST_ENABLE, ST_DISABLE, ST_TEARDOWN:
        begin
          if (tick)
          begin
            if (cnt_r >= cur_dly)
            begin
              cnt_r <= 16'h0000;
              case (state_r)
                ST_POWER:
                begin
                  state_r <= ST_WAKE;
                  o_rf_power_down_ctl <= 1'b1;
                end
                ST_WAKE:
                begin
                  state_r <= ST_ENABLE;
                  o_carrier_enable <= 1'b1;
                end
                ST_ENABLE:
                begin
                  state_r <= ST_MESSAGE;
                  // Keyed mode holds carrier off until an element keys it
                  o_carrier_enable <= ~keyed_r;
                  // Gated supply stays off until the first chirp
                  o_rf_board_power <= ~chirp_gate_r;
                end
                ST_DISABLE:
                begin
                  state_r <= ST_TEARDOWN;
                  o_rf_power_down_ctl <= 1'b0;
                  o_rf_board_power <= 1'b0;
                end
                default:
                begin
                  state_r <= ST_IDLE;
                  msg_done_r <= 1'b1;
                end
              endcase
            end
            else
              cnt_r <= cnt_r + 16'h0001;
          end
        end
        ST_MESSAGE:
        begin
          // No delay here; duration comes from the elements alone
          if (!elem_busy_r && elem_valid_r)
          begin
            elem_busy_r <= 1'b1;
            cnt_r <= 16'h0000;
            o_tone_gate <= (elem_kind_r != `KIND_GAP) && (tone_r != 16'h0000);
            // Chirps key the carrier just as tones do
            if (keyed_r && elem_kind_r != `KIND_GAP)
              o_carrier_enable <= (tone_r != 16'h0000);
            if (keyed_r && elem_kind_r == `KIND_SPEECH)
              o_carrier_enable <= 1'b1;
            if (chirp_gate_r && (elem_kind_r == `KIND_CHIRP))
              o_rf_board_power <= 1'b1;
          end
          else if (elem_busy_r && tick)
          begin
            if (cnt_r + 16'h0001 >= elem_len_r)
            begin
              elem_busy_r <= 1'b0;
              elem_valid_r <= 1'b0;
              o_tone_gate <= 1'b0;
              if (keyed_r)
                o_carrier_enable <= 1'b0;
              if (chirp_gate_r && elem_kind_r == `KIND_CHIRP)
                o_rf_board_power <= 1'b0;
              if (elem_last_r)
              begin
                state_r <= ST_DISABLE;
                cnt_r <= 16'h0000;
                o_carrier_enable <= 1'b0;
                o_rf_board_power <= 1'b1;
              end
            end
            else
              cnt_r <= cnt_r + 16'h0001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // After the idle clear, so a start landing in idle is never lost
      if (wr_en && wr_full && wr_addr == `REG_CTRL && wr_data[`CTRL_START])
        start_pend_r <= 1'b1;
    end
  end
endmodule // rf_transmit_slot_sequencer
`default_nettype wire

// ### test/slot_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module slot_seq_checker #(
  parameter integer TICK_CYCLES = 4
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_arvalid,
  input wire o_arready,
  input wire i_rready,
  input wire o_rvalid,
  input wire [31:0] o_rdata,
  input wire i_bready,
  input wire o_bvalid,
  input wire [1:0] o_bresp,
  input wire o_rf_board_power,
  input wire o_rf_power_down_ctl,
  input wire o_carrier_enable,
  input wire o_tone_gate
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  a_carrier_ctl: assert property (o_carrier_enable |-> o_rf_power_down_ctl)
    else $error("carrier on outside wake");
  a_wake_after_pwr: assert property ($rose(o_rf_power_down_ctl) |-> $past(o_rf_board_power) && !$past(o_carrier_enable))
    else $error("wake without board power");
  a_pwr_slot_first: assert property ($rose(o_rf_board_power) && !o_rf_power_down_ctl |-> !o_carrier_enable && !o_tone_gate)
    else $error("power slot not first");
  a_tone_carrier: assert property (o_tone_gate |-> o_carrier_enable)
    else $error("tone without carrier");
  a_teardown_both: assert property ($fell(o_rf_power_down_ctl) |-> $fell(o_rf_board_power) && !o_carrier_enable)
    else $error("teardown not together");
  // One tick minimum quiet time even with a zero delay
  a_quiet_tail: assert property ($fell(o_rf_power_down_ctl) |-> !$past(o_carrier_enable, TICK_CYCLES))
    else $error("no quiet time before teardown");
  a_enable_after_wake: assert property ($rose(o_carrier_enable) |-> $past(o_rf_power_down_ctl, TICK_CYCLES))
    else $error("carrier before wake slot ran");
  a_read_lat: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response not held");
  c_teardown: cover property ($fell(o_rf_power_down_ctl));
  c_tone: cover property ($rose(o_tone_gate));
  c_gate: cover property ($fell(o_rf_board_power) && o_rf_power_down_ctl);
endmodule // slot_seq_checker
bind rf_transmit_slot_sequencer slot_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_rready(i_rready), .o_rvalid(o_rvalid),
  .o_rdata(o_rdata), .i_bready(i_bready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
  .o_rf_board_power(o_rf_board_power), .o_rf_power_down_ctl(o_rf_power_down_ctl),
  .o_carrier_enable(o_carrier_enable), .o_tone_gate(o_tone_gate));
`default_nettype wire

// ### test/rf_module_model.sv
`timescale 1ns/1ps
`default_nettype none
module rf_module_model #(
  parameter integer WAKE_CYCLES = 4
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_power,
  input wire i_ctl,
  input wire i_carrier,
  output logic o_early
);
  integer awake_cnt;
  logic carrier_q;
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      awake_cnt <= 0;
      carrier_q <= 1'b0;
      o_early <= 1'b0;
    end
    else
    begin
      awake_cnt <= (i_power && i_ctl) ? awake_cnt + 1 : 0;
      carrier_q <= i_carrier;
      // Keyed too soon, the radio drops the first element
      if (i_carrier && !carrier_q && awake_cnt < WAKE_CYCLES)
        o_early <= 1'b1;
    end
  end
endmodule // rf_module_model
`default_nettype wire

// ### test/rf_transmit_slot_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rf_transmit_slot_sequencer_tb_top;
  localparam integer T = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, g;
  logic [31:0] wdata = 32'h0, rd_v;
  logic [3:0] wstrb = 4'hf, cm = 4'hf, last_v = 4'h0, v;
  wire awready, wready, bvalid, arready, rvalid, pwr, ctl, car, tone, early;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer bad_count = 0, check_count = 0, cyc = 0, lt = 0, n;
  integer d[5];
  logic [31:0] dv[6] = '{32'h320, 32'ha, 32'h5dc, 32'h64, 32'ha, 32'ha};
  logic [34:0] rq[$];
  logic [34:0] x;
  logic [1:0] bq[$];
  logic [15:0] eq[$];
  logic [15:0] e;

  always #2.5 clk = ~clk;

  rf_transmit_slot_sequencer #(.TICK_CYCLES(T)) dut (.i_sys_clk(clk), .i_rst(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_rf_board_power(pwr), .o_rf_power_down_ctl(ctl), .o_carrier_enable(car),
    .o_tone_gate(tone));
  rf_module_model #(.WAKE_CYCLES(T)) u_rf (.i_sys_clk(clk), .i_rst(rst), .i_power(pwr), .i_ctl(ctl),
    .i_carrier(car), .o_early(early));

  task chk(input string nm, input [33:0] xe, input [33:0] xg);
    check_count++;
    if (xe !== xg)
    begin
      bad_count++;
      $display("ERROR %s exp %h got %h", nm, xe, xg);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task wr(input [7:0] a, input [31:0] dat, input [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      g = bvalid;
    end while (!g);
    bready <= 1'b0;
  endtask

  task rd(input [7:0] a, input [34:0] xe);
    rq.push_back(xe);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      g = rvalid;
    end while (!g);
    rd_v = rdata;
    rready <= 1'b0;
  endtask

  task ws(input [31:0] m, input [31:0] xv);
    do rd(8'h08, 35'h0); while ((rd_v & m) !== xv);
  endtask

  task ex(input integer k, input [3:0] xv);
    eq.push_back({8'(k), cm, xv});
  endtask

  task el(input [1:0] k, input l, input [15:0] len);
    ws(32'h400, 32'h0);
    wr(8'h24, {8'h0, len, 5'h0, l, k}, 2'h0);
  endtask

  task dflt;
    foreach (dv[i]) rd(8'(12 + 4 * i), {3'b100, dv[i]});
  endtask

  task run(input [3:0] m, input [15:0] tn);
    wr(8'h04, {28'h0, m}, 2'h0);
    rd(8'h04, {3'b100, 28'h0, m[3], ~(|m[1:0] & ~m[2]), |m[1:0] & ~m[2], |m[1:0] & ~m[2]});
    wr(8'h0c, {16'h0, tn}, 2'h0);
    foreach (d[i])
    begin
      d[i] = 1 + $urandom % 3;
      wr(8'(16 + 4 * i), d[i], 2'h0);
    end
    ex(0, 4'h8);
    ex(d[0], 4'hc);
    ex(d[1], 4'he);
    if (m[1:0] != 2'h0) ex(d[2], 4'hc);
    if (m[3]) ex(d[2], 4'h6);
    wr(8'h00, 32'h1, 2'h0);
    ws(32'h70, 32'h40);
  endtask

  task fin;
    ws(32'h70, 32'h0);
    rd(8'h08, {3'b100, 32'h200});
  endtask

  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (rvalid && rready)
    begin
      x = rq.pop_front();
      if (x[34]) chk("rdata", x[33:0], {rresp, rdata});
    end
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    v = {pwr, ctl, car, tone};
    if (eq.size() != 0 && ((v ^ last_v) & eq[0][7:4]) != 4'h0)
    begin
      e = eq.pop_front();
      chk("outputs", e[3:0] & e[7:4], v & e[7:4]);
      if (e[15:8] != 0) chk("slot_len", 34'h1, 34'(cyc - lt >= e[15:8] * T && cyc - lt <= (e[15:8] + 1) * T + 2));
      lt = cyc;
      last_v = v;
    end
    else if (eq.size() == 0 && v !== last_v)
    begin
      chk("idle_outputs", last_v, v);
      last_v = v;
    end
    // A hung poll or lost handshake ends here
    if (cyc == 40000)
    begin
      bad_count++;
      finish_test;
    end
  end

  initial
  begin
    void'($urandom(91));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    dflt();
    wr(8'h40, 32'h5, 2'h2);
    rd(8'h40, {3'b110, 32'h0});
    // Plain carrier run: tone then quiet gap ends the message
    cm = 4'hf;
    run(4'h4, 16'h320);
    n = 2 + $urandom % 3;
    ex(0, 4'hf);
    ex(n - 1, 4'he);
    ex(0, 4'hc);
    ex(d[3], 4'h0);
    el(2'h0, 1'b0, 16'(n));
    el(2'h1, 1'b1, 16'h2);
    fin();
    // Keyed through the alias bit, then speech
    run(4'h2, 16'h320);
    n = 2 + $urandom % 3;
    ex(0, 4'hf);
    ex(n - 1, 4'hc);
    cm = 4'he;
    ex(0, 4'he);
    ex(0, 4'hc);
    ex(d[3], 4'h0);
    el(2'h0, 1'b0, 16'(n));
    el(2'h1, 1'b0, 16'h1);
    el(2'h3, 1'b1, 16'h1);
    fin();
    // Keyed with tone off leaves the carrier dark
    cm = 4'hf;
    run(4'h1, 16'h0);
    ex(0, 4'h0);
    el(2'h0, 1'b0, 16'h2);
    el(2'h1, 1'b1, 16'h1);
    fin();
    // Chirp gating drops board power between chirps
    cm = 4'he;
    run(4'hc, 16'h320);
    ex(0, 4'he);
    ex(1, 4'h6);
    // Gap to the next chirp includes bus polling, so it is not timed
    ex(0, 4'he);
    ex(0, 4'hc);
    ex(d[3], 4'h0);
    el(2'h2, 1'b0, 16'h2);
    el(2'h1, 1'b0, 16'h2);
    el(2'h2, 1'b1, 16'h1);
    fin();
    // Keyed and FM together: FM wins as the clear
    wr(8'h04, 32'h7, 2'h0);
    rd(8'h04, {3'b100, 32'h4});
    wr(8'h00, 32'h2, 2'h0);
    dflt();
    chk("early_carrier", 34'h0, {33'h0, early});
    finish_test;
  end
endmodule // rf_transmit_slot_sequencer_tb_top
`default_nettype wire
